//--- core/sfes_core.sv
// Operation
// R1: opcode 20h plus address erases the addressed 4K sector to FFh.
// R2: opcode D8h plus address erases the addressed 64K block to FFh.
// R3: opcode C7h alone erases the whole array to FFh.
// R4: erase accepted only with write enable latch set; host enables first.
// R5: chip select must rise right after final byte; otherwise discard.
// R6: chip select rise starts timed erase; busy high throughout, then low.
// R7: status read still works during an erase cycle.
// R8: write enable latch cleared when an erase cycle completes.
// R9: sector or block erase refused inside the protected region.
// R10: chip erase refused if any protection is set.
// R11: B9h then chip select rise enters sleep within entry delay.
// R12: in sleep only ABh is recognised; all else ignored.
// R13: device comes up awake, not sleeping.
// R14: ABh alone wakes; chip select stays high for plain wake delay.
// R15: ABh plus three dummy bytes streams device identity repeatedly.
// R16: ABh with identity read from sleep uses the longer wake delay.
// R17: ABh while busy is ignored; ongoing cycle unaffected.
// R18: 90h plus zero address streams manufacturer then device identity.
// R19: 90h address one gives device first; bytes alternate until deselect.
// R20: 9Fh streams manufacturer, memory type, then capacity bytes.
// R21: opcode and address bits captured on serial clock rising edges.
// R22: host sends MSB first and ignores output while deselected.
`timescale 1ns/10ps
module sfes_core #(
  parameter int unsigned SECTOR_ERASE_CYCLES = sfes_pkg::SECTOR_ERASE_CYC,
  parameter int unsigned BLOCK_ERASE_CYCLES = sfes_pkg::BLOCK_ERASE_CYC,
  parameter int unsigned CHIP_ERASE_CYCLES = sfes_pkg::CHIP_ERASE_CYC
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire logic SPI_CS_N,
  input wire logic SPI_SCLK,
  input wire logic SERIAL_IN_LINE,
  input wire logic WEL_SET,
  input wire logic PROTECT_REGION_DIRECTION,
  input wire logic PROTECT_SIZE_BIT_HIGH,
  input wire logic PROTECT_SIZE_BIT_MID,
  input wire logic PROTECT_SIZE_BIT_LOW,
  output logic SPI_SO,
  output logic SPI_SO_OE,
  output logic WRITE_ENABLE_LATCH,
  output logic BUSY,
  output logic SLEEPING,
  output logic ERASE_STROBE,
  output logic [sfes_pkg::ADDR_W-1:0] ERASE_BASE,
  output logic [1:0] ERASE_SCOPE
);
  import sfes_pkg::*;

  // ****************************************
  // serial front end
  // ****************************************
  logic sclk_d_ff, nxt_sclk_d;
  logic cs_d_ff, nxt_cs_d;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [2:0] byte_cnt_ff, nxt_byte_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] opcode_ff, nxt_opcode;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [1:0] out_sel_ff, nxt_out_sel;
  logic so_ff, nxt_so;
  logic so_oe_ff, nxt_so_oe;
  logic sleeping_ff, busy_ff, wel_ff;
  logic sclk_rise, sclk_fall, cs_rise;
  logic [2:0] hdr_len;
  logic out_allowed, in_data;
  logic [7:0] out_byte;

  assign sclk_rise = !SPI_CS_N && SPI_SCLK && !sclk_d_ff;
  assign sclk_fall = !SPI_CS_N && !SPI_SCLK && sclk_d_ff;
  assign cs_rise = SPI_CS_N && !cs_d_ff;
  assign in_data = out_allowed && (byte_cnt_ff >= hdr_len);

  always_comb begin
    hdr_len = NO_DATA_PHASE;
    out_allowed = 1'b0;
    out_byte = 8'h00;
    unique case (opcode_ff)
      // R15: identity repeated
      // R17: silent while busy
      OP_WAKE_ID: begin
        hdr_len = ADDR_FRAME_BYTES;
        out_allowed = !busy_ff;
        out_byte = DEV_ID;
      end
      // R18: manufacturer then device
      // R19: order set by address bit
      OP_MFG_DEV_ID: begin
        hdr_len = ADDR_FRAME_BYTES;
        out_allowed = !busy_ff && !sleeping_ff;
        out_byte = (out_sel_ff[0] ^ addr_ff[0]) ? DEV_ID : MFG_ID;
      end
      // R20: three jedec bytes
      OP_JEDEC_ID: begin
        hdr_len = OP_FRAME_BYTES;
        out_allowed = !busy_ff && !sleeping_ff;
        out_byte = (out_sel_ff == 2'h0) ? MFG_ID : ((out_sel_ff == 2'h1) ? MEM_TYPE_ID : CAPACITY_ID);
      end
      // R7: status during erase
      OP_READ_STATUS: begin
        hdr_len = OP_FRAME_BYTES;
        out_allowed = !sleeping_ff;
        out_byte = {6'h00, wel_ff, busy_ff};
      end
      default: begin
        hdr_len = NO_DATA_PHASE;
      end
    endcase
  end

  always_comb begin
    nxt_sclk_d = SPI_SCLK;
    nxt_cs_d = SPI_CS_N;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_byte_cnt = byte_cnt_ff;
    nxt_shift = shift_ff;
    nxt_opcode = opcode_ff;
    nxt_addr = addr_ff;
    nxt_out_sel = out_sel_ff;
    nxt_so = so_ff;
    nxt_so_oe = so_oe_ff;
    if (SPI_CS_N) begin
      nxt_bit_cnt = 3'h0;
      nxt_byte_cnt = 3'h0;
      nxt_out_sel = 2'h0;
      nxt_so_oe = 1'b0;
      nxt_so = 1'b0;
    end else begin
      // R21: capture on rising edge
      if (sclk_rise) begin
        nxt_shift = {shift_ff[6:0], SERIAL_IN_LINE};
        nxt_bit_cnt = bit_cnt_ff + 3'h1;
        if (byte_cnt_ff != 3'h0 && byte_cnt_ff < ADDR_FRAME_BYTES) begin
          nxt_addr = {addr_ff[ADDR_W-2:0], SERIAL_IN_LINE};
        end
        if (bit_cnt_ff == 3'h7) begin
          if (byte_cnt_ff == 3'h0) begin
            nxt_opcode = {shift_ff[6:0], SERIAL_IN_LINE};
          end
          if (byte_cnt_ff != 3'h7) begin
            nxt_byte_cnt = byte_cnt_ff + 3'h1;
          end
          if (in_data) begin
            nxt_out_sel = (opcode_ff == OP_JEDEC_ID && out_sel_ff == 2'h2) ? 2'h0 : out_sel_ff + 2'h1;
          end
        end
      end
      // R12: sleep gates all but wake
      if (sclk_fall) begin
        nxt_so_oe = in_data;
        nxt_so = in_data ? out_byte[3'h7 - bit_cnt_ff] : 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      opcode_ff <= 8'h00;
      addr_ff <= 24'h00_0000;
      out_sel_ff <= 2'h0;
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else if (CLK_EN) begin
      sclk_d_ff <= nxt_sclk_d;
      cs_d_ff <= nxt_cs_d;
      bit_cnt_ff <= nxt_bit_cnt;
      byte_cnt_ff <= nxt_byte_cnt;
      shift_ff <= nxt_shift;
      opcode_ff <= nxt_opcode;
      addr_ff <= nxt_addr;
      out_sel_ff <= nxt_out_sel;
      so_ff <= nxt_so;
      so_oe_ff <= nxt_so_oe;
    end
  end

  // ****************************************
  // protection decode
  // ****************************************
  logic [2:0] bp;
  logic [5:0] prot_blocks, blk_idx;
  logic prot_hit, any_prot;

  assign bp = {PROTECT_SIZE_BIT_HIGH, PROTECT_SIZE_BIT_MID, PROTECT_SIZE_BIT_LOW};
  assign any_prot = (bp != 3'h0);
  assign blk_idx = {1'b0, addr_ff[BLK_LSB +: BLK_W]};

  always_comb begin
    prot_blocks = 6'h00;
    prot_hit = 1'b0;
    if (bp >= BP_ALL) begin
      prot_hit = 1'b1;
    end else if (any_prot) begin
      prot_blocks = 6'h01 << (bp - 3'h1);
      prot_hit = PROTECT_REGION_DIRECTION ? (blk_idx < prot_blocks) : (blk_idx >= BLK_COUNT - prot_blocks);
    end
  end

  // ****************************************
  // erase and sleep sequencer
  // ****************************************
  sfes_state_type state_ff, nxt_state;
  logic [31:0] timer_ff, nxt_timer;
  logic nxt_wel, nxt_busy, nxt_sleeping, strobe_ff, nxt_strobe;
  logic [ADDR_W-1:0] base_ff, nxt_base;
  logic [1:0] scope_ff, nxt_scope;
  logic addr_frame_ok, op_frame_ok;

  assign addr_frame_ok = (byte_cnt_ff == ADDR_FRAME_BYTES) && (bit_cnt_ff == 3'h0);
  assign op_frame_ok = (byte_cnt_ff == OP_FRAME_BYTES) && (bit_cnt_ff == 3'h0);

  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    nxt_wel = wel_ff;
    nxt_strobe = 1'b0;
    nxt_base = base_ff;
    nxt_scope = scope_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (cs_rise) begin
          // R4: latch gates erase
          // R5: exact framing only
          // R1: sector erase
          if (opcode_ff == OP_SECTOR_ERASE && addr_frame_ok && wel_ff && !prot_hit) begin // R9: protect check
            nxt_state = ST_ERASE;
            nxt_timer = SECTOR_ERASE_CYCLES - 32'h1;
            nxt_strobe = 1'b1;
            nxt_base = addr_ff & SECTOR_MASK;
            nxt_scope = SCOPE_SECTOR;
          // R2: block erase
          end else if (opcode_ff == OP_BLOCK_ERASE && addr_frame_ok && wel_ff && !prot_hit) begin
            nxt_state = ST_ERASE;
            nxt_timer = BLOCK_ERASE_CYCLES - 32'h1;
            nxt_strobe = 1'b1;
            nxt_base = addr_ff & BLOCK_MASK;
            nxt_scope = SCOPE_BLOCK;
          // R3: chip erase
          end else if (opcode_ff == OP_CHIP_ERASE && op_frame_ok && wel_ff && !any_prot) begin // R10: any protect
            nxt_state = ST_ERASE;
            nxt_timer = CHIP_ERASE_CYCLES - 32'h1;
            nxt_strobe = 1'b1;
            nxt_base = 24'h00_0000;
            nxt_scope = SCOPE_CHIP;
          // R11: sleep entry
          end else if (opcode_ff == OP_SLEEP && op_frame_ok) begin
            nxt_state = ST_ENTER;
            nxt_timer = SLEEP_ENTRY_CYC - 1;
          end
        end
      end
      // R6: self-timed busy
      ST_ERASE: begin
        nxt_timer = timer_ff - 32'h1;
        if (timer_ff == 32'h0) begin
          nxt_state = ST_IDLE;
          // R8: clear latch on finish
          nxt_wel = 1'b0;
        end
      end
      ST_ENTER: begin
        nxt_timer = timer_ff - 32'h1;
        if (timer_ff == 32'h0) begin
          nxt_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (cs_rise && opcode_ff == OP_WAKE_ID && byte_cnt_ff != 3'h0 && bit_cnt_ff == 3'h0) begin
          nxt_state = ST_WAKE;
          // R14: plain wake delay
          // R16: longer after id read
          nxt_timer = op_frame_ok ? WAKE_PLAIN_CYC - 1 : WAKE_ID_CYC - 1;
        end
      end
      ST_WAKE: begin
        nxt_timer = timer_ff - 32'h1;
        if (!SPI_CS_N) begin
          nxt_state = ST_SLEEP;
        end else if (timer_ff == 32'h0) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
    if (WEL_SET) begin
      nxt_wel = 1'b1;
    end
    nxt_busy = (nxt_state == ST_ERASE);
    nxt_sleeping = (nxt_state == ST_SLEEP) || (nxt_state == ST_WAKE);
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      // R13: awake after power-up
      state_ff <= ST_IDLE;
      timer_ff <= 32'h0000_0000;
      wel_ff <= 1'b0;
      busy_ff <= 1'b0;
      sleeping_ff <= 1'b0;
      strobe_ff <= 1'b0;
      base_ff <= 24'h00_0000;
      scope_ff <= 2'h0;
    end else if (CLK_EN) begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      wel_ff <= nxt_wel;
      busy_ff <= nxt_busy;
      sleeping_ff <= nxt_sleeping;
      strobe_ff <= nxt_strobe;
      base_ff <= nxt_base;
      scope_ff <= nxt_scope;
    end
  end

  assign SPI_SO = so_ff;
  assign SPI_SO_OE = so_oe_ff;
  assign WRITE_ENABLE_LATCH = wel_ff;
  assign BUSY = busy_ff;
  assign SLEEPING = sleeping_ff;
  assign ERASE_STROBE = strobe_ff;
  assign ERASE_BASE = base_ff;
  assign ERASE_SCOPE = scope_ff;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  property p_erase_needs_wel;
    $rose(busy_ff) |-> $past(wel_ff);
  endproperty
  a_erase_needs_wel: assert property (p_erase_needs_wel) else $error("erase started without latch"); // R4

  property p_erase_framed;
    $rose(busy_ff) |-> $past(bit_cnt_ff) == 3'h0 && $past(cs_rise);
  endproperty
  a_erase_framed: assert property (p_erase_framed) else $error("erase started off frame"); // R5

  property p_strobe_busy;
    strobe_ff |-> busy_ff && $past(state_ff) == ST_IDLE;
  endproperty
  a_strobe_busy: assert property (p_strobe_busy) else $error("strobe without busy"); // R6

  property p_wel_cleared;
    $fell(busy_ff) |-> !wel_ff || $past(WEL_SET);
  endproperty
  a_wel_cleared: assert property (p_wel_cleared) else $error("latch kept after erase"); // R8

  property p_no_protected;
    strobe_ff && scope_ff != SCOPE_CHIP |-> !$past(prot_hit);
  endproperty
  a_no_protected: assert property (p_no_protected) else $error("protected region erased"); // R9

  property p_chip_unprotected;
    strobe_ff && scope_ff == SCOPE_CHIP |-> !$past(any_prot);
  endproperty
  a_chip_unprotected: assert property (p_chip_unprotected) else $error("chip erase while protected"); // R10

  property p_sleep_entry;
    $rose(sleeping_ff) |-> $past(state_ff) == ST_ENTER;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep without entry phase"); // R11

  property p_sleep_output;
    sleeping_ff && so_oe_ff |-> opcode_ff == OP_WAKE_ID;
  endproperty
  a_sleep_output: assert property (p_sleep_output) else $error("output in sleep"); // R12

  property p_busy_output;
    busy_ff && so_oe_ff |-> opcode_ff == OP_READ_STATUS;
  endproperty
  a_busy_output: assert property (p_busy_output) else $error("id answered while busy"); // R17

endmodule

//--- core/sfes_pkg.sv
package sfes_pkg;

  // ****************************************
  // instruction codes
  // ****************************************
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_ID = 8'hAB;
  localparam logic [7:0] OP_MFG_DEV_ID = 8'h90;
  localparam logic [7:0] OP_JEDEC_ID = 8'h9F;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;

  // ****************************************
  // identity bytes (values arbitrary)
  // ****************************************
  localparam logic [7:0] MFG_ID = 8'h5A;
  localparam logic [7:0] DEV_ID = 8'h14;
  localparam logic [7:0] MEM_TYPE_ID = 8'h30;
  localparam logic [7:0] CAPACITY_ID = 8'h15;

  // ****************************************
  // geometry and framing
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int BLK_LSB = 16;
  localparam int BLK_W = 5;
  localparam logic [5:0] BLK_COUNT = 6'h20;
  localparam logic [2:0] BP_ALL = 3'h6;
  localparam logic [2:0] ADDR_FRAME_BYTES = 3'h4;
  localparam logic [2:0] OP_FRAME_BYTES = 3'h1;
  localparam logic [2:0] NO_DATA_PHASE = 3'h7;
  localparam logic [23:0] SECTOR_MASK = 24'hFF_F000;
  localparam logic [23:0] BLOCK_MASK = 24'hFF_0000;
  localparam logic [1:0] SCOPE_SECTOR = 2'h0;
  localparam logic [1:0] SCOPE_BLOCK = 2'h1;
  localparam logic [1:0] SCOPE_CHIP = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 10;
  localparam int SLEEP_ENTRY_US = 3;
  localparam int WAKE_PLAIN_US = 3;
  localparam int WAKE_ID_US = 6;
  localparam int SECTOR_ERASE_MS = 150;
  localparam int BLOCK_ERASE_MS = 1000;
  localparam int CHIP_ERASE_MS = 30000;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CLK_MHZ;
  localparam int WAKE_PLAIN_CYC = WAKE_PLAIN_US * CLK_MHZ;
  localparam int WAKE_ID_CYC = WAKE_ID_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_MS * 1000 * CLK_MHZ;
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_MS * 1000 * CLK_MHZ;
  localparam int CHIP_ERASE_CYC = CHIP_ERASE_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_ENTER, ST_SLEEP, ST_WAKE} sfes_state_type;

endpackage

//--- test/sfes_host.sv
`timescale 1ns/10ps
module sfes_host (
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe,
  output logic cs_n,
  output logic sclk,
  output logic si
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // ****************************************
  // one framed transfer, five clocks a bit
  // ****************************************
  task automatic frame(input logic [31:0] tx, input int nb, input int nr, output logic [31:0] rx,
                       output logic oe_any);
    rx = 32'h0000_0000;
    oe_any = 1'b0;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < nb + nr; i++) begin
      @(negedge clk);
      sclk = 1'b0;
      si = (i < nb && i < 32) ? tx[31 - i] : ~si;
      repeat (2) @(negedge clk);
      if (i >= nb) begin
        rx = {rx[30:0], so};
        oe_any = oe_any | so_oe;
      end
      // low phase spans two core clocks, high phase three (two on the last bit)
      sclk = 1'b1;
      repeat (2) @(negedge clk);
    end
    sclk = 1'b0;
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    si = ~si;
    repeat (2) @(negedge clk);
  endtask
endmodule

//--- test/spi_flash_erase_sleep_id_tb_top.sv
`timescale 1ns/10ps
module spi_flash_erase_sleep_id_tb_top;
  import sfes_pkg::*;
  typedef struct {logic [31:0] tx; int nb; int nr; logic [31:0] ex;} sfes_row_type;
  localparam int SEC_C = 500;
  localparam int BLK_C = 450;
  localparam int CHP_C = 400;
  logic core_clk, arst_n, cs_n, sclk, si, wel_set, dir, so, so_oe, write_enable_latch, busy, sleeping, strobe;
  logic [2:0] bp;
  logic [23:0] base, base_q;
  logic [1:0] scope, scope_q;
  logic [31:0] rx;
  logic oe;
  int fails = 0;
  int n_tests = 0;
  int n_strb = 0;
  int busy_cyc = 0;
  sfes_row_type rows [5] = '{
    '{{OP_JEDEC_ID, 24'h00_0000}, 8, 32, {MFG_ID, MEM_TYPE_ID, CAPACITY_ID, MFG_ID}},
    '{{OP_MFG_DEV_ID, 24'h00_0000}, 32, 24, {8'h00, MFG_ID, DEV_ID, MFG_ID}},
    '{{OP_MFG_DEV_ID, 24'h00_0001}, 32, 24, {8'h00, DEV_ID, MFG_ID, DEV_ID}},
    '{{OP_WAKE_ID, 24'h00_0000}, 32, 16, {16'h0000, DEV_ID, DEV_ID}},
    '{{OP_READ_STATUS, 24'h00_0000}, 8, 8, 32'h0000_0000}};

  sfes_core #(.SECTOR_ERASE_CYCLES(SEC_C), .BLOCK_ERASE_CYCLES(BLK_C), .CHIP_ERASE_CYCLES(CHP_C)) dut_u (
    .CORE_CLK(core_clk), .ARST_N(arst_n), .CLK_EN(1'b1), .SPI_CS_N(cs_n), .SPI_SCLK(sclk),
    .SERIAL_IN_LINE(si), .WEL_SET(wel_set), .PROTECT_REGION_DIRECTION(dir), .PROTECT_SIZE_BIT_HIGH(bp[2]),
    .PROTECT_SIZE_BIT_MID(bp[1]), .PROTECT_SIZE_BIT_LOW(bp[0]), .SPI_SO(so), .SPI_SO_OE(so_oe),
    .WRITE_ENABLE_LATCH(write_enable_latch), .BUSY(busy), .SLEEPING(sleeping), .ERASE_STROBE(strobe),
    .ERASE_BASE(base), .ERASE_SCOPE(scope));
  sfes_host host_u (.clk(core_clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sclk(sclk), .si(si));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    busy_cyc <= busy_cyc + ((busy === 1'b1) ? 1 : 0);
    if (strobe === 1'b1) begin
      n_strb <= n_strb + 1;
      base_q <= base;
      scope_q <= scope;
    end
  end

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input string name, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, ex, got);
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic erase(input logic [31:0] tx, input int nb, input logic w, input logic ok,
                       input logic [23:0] eb, input logic [1:0] es, input int cyc);
    int s;
    int b;
    s = n_strb;
    b = busy_cyc;
    wel_set = w;
    @(negedge core_clk);
    wel_set = 1'b0;
    host_u.frame(tx, nb, 0, rx, oe);
    if (ok) begin
      host_u.frame({OP_READ_STATUS, 24'h00_0000}, 8, 8, rx, oe);
      chk("busy_status", 32'h0000_0003, rx);
      host_u.frame({OP_WAKE_ID, 24'h00_0000}, 32, 8, rx, oe);
      chk("busy_id_oe", 32'h0000_0000, 32'(oe));
    end
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge core_clk);
    chk("strobes", 32'(ok), 32'(n_strb - s));
    chk("busy_cycles", ok ? 32'(cyc) : 32'h0000_0000, 32'(busy_cyc - b));
    chk("wel", 32'(ok ? 1'b0 : w), 32'(write_enable_latch));
    if (ok) begin
      chk("base", 32'(eb), 32'(base_q));
      chk("scope", 32'(es), 32'(scope_q));
    end
  endtask

  initial begin
    #(100 * 60000);
    fails++;
    complete_run();
  end

  initial begin
    arst_n = 1'b0;
    wel_set = 1'b0;
    dir = 1'b0;
    bp = 3'h0;
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    chk("reset_out", 32'h0000_0000, 32'({sleeping, busy, write_enable_latch, so_oe}));
    for (int i = 0; i < 5; i++) begin
      host_u.frame(rows[i].tx, rows[i].nb, rows[i].nr, rx, oe);
      chk("id_read", rows[i].ex, rx);
      chk("id_oe", 32'h0000_0001, 32'(oe));
    end
    erase({OP_SECTOR_ERASE, 24'h12_3456}, 32, 0, 0, 24'h00_0000, 2'h0, 0);
    erase({OP_SECTOR_ERASE, 24'h12_3456}, 32, 1, 1, 24'h12_3000, SCOPE_SECTOR, SEC_C);
    erase({OP_BLOCK_ERASE, 24'h05_6789}, 32, 1, 1, 24'h05_0000, SCOPE_BLOCK, BLK_C);
    erase({OP_CHIP_ERASE, 24'h00_0000}, 8, 1, 1, 24'h00_0000, SCOPE_CHIP, CHP_C);
    erase({OP_SECTOR_ERASE, 24'h12_3456}, 31, 1, 0, 24'h00_0000, 2'h0, 0);
    erase({OP_SECTOR_ERASE, 24'h12_3456}, 33, 1, 0, 24'h00_0000, 2'h0, 0);
    erase({OP_CHIP_ERASE, 24'h00_0000}, 9, 1, 0, 24'h00_0000, 2'h0, 0);
    bp = 3'h1;
    erase({OP_SECTOR_ERASE, 24'h1F_F000}, 32, 1, 0, 24'h00_0000, 2'h0, 0);
    erase({OP_SECTOR_ERASE, 24'h00_1234}, 32, 1, 1, 24'h00_1000, SCOPE_SECTOR, SEC_C);
    dir = 1'b1;
    erase({OP_BLOCK_ERASE, 24'h00_8000}, 32, 1, 0, 24'h00_0000, 2'h0, 0);
    erase({OP_CHIP_ERASE, 24'h00_0000}, 8, 1, 0, 24'h00_0000, 2'h0, 0);
    bp = 3'h0;
    host_u.frame({OP_SLEEP, 24'h00_0000}, 8, 0, rx, oe);
    repeat (40) @(negedge core_clk);
    chk("sleep_entry", 32'h0000_0001, 32'(sleeping));
    host_u.frame({OP_READ_STATUS, 24'h00_0000}, 8, 8, rx, oe);
    chk("sleep_status_oe", 32'h0000_0000, 32'(oe));
    host_u.frame({OP_WAKE_ID, 24'h00_0000}, 8, 0, rx, oe);
    chk("wake_wait", 32'h0000_0001, 32'(sleeping));
    repeat (35) @(negedge core_clk);
    chk("wake_plain", 32'h0000_0000, 32'(sleeping));
    host_u.frame({OP_SLEEP, 24'h00_0000}, 8, 0, rx, oe);
    repeat (40) @(negedge core_clk);
    host_u.frame({OP_WAKE_ID, 24'h00_0000}, 32, 8, rx, oe);
    chk("wake_id", 32'(DEV_ID), rx);
    repeat (35) @(negedge core_clk);
    chk("wake_long_wait", 32'h0000_0001, 32'(sleeping));
    repeat (30) @(negedge core_clk);
    chk("wake_long", 32'h0000_0000, 32'(sleeping));
    complete_run();
  end
endmodule
